// [include/pot_map.svh]
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

// Serial word layout
`define FRAME_BITS        24
`define CMD_BITS          4
`define ADDR_BITS         4
`define DATA_BITS         16
`define POS_BITS          5
`define POS_FIRST         5'h00
`define POS_LAST          5'h17
`define FRAME_MSB         23

// Wiper scale
`define WIPER_BITS        10
`define WIPER_ZERO        10'h000
`define WIPER_ONE         10'h001
`define WIPER_MID         10'h200
`define WIPER_FULL        10'h3FF

// Command codes
`define CMD_NOP           4'h0
`define CMD_RESTORE       4'h1
`define CMD_SAVE          4'h2
`define CMD_NV_WRITE      4'h3
`define CMD_SHR_ONE       4'h4
`define CMD_SHR_ALL       4'h5
`define CMD_DEC_ONE       4'h6
`define CMD_DEC_ALL       4'h7
`define CMD_RESTORE_ALL   4'h8
`define CMD_NV_READ       4'h9
`define CMD_WIPER_READ    4'hA
`define CMD_WIPER_WRITE   4'hB
`define CMD_SHL_ONE       4'hC
`define CMD_SHL_ALL       4'hD
`define CMD_INC_ONE       4'hE
`define CMD_INC_ALL       4'hF

// Nonvolatile word map
`define NV_WORDS          16
`define NV_ADDR_SAVED_ONE 4'h0
`define NV_ADDR_SAVED_TWO 4'h1
`define NV_ADDR_TOLERANCE 4'hF
`define NV_FACTORY_WIPER  16'h0200
`define NV_FACTORY_USER   16'h0000
`define NV_FACTORY_TOL    16'h8000

`endif

// [include/pot_pkg.sv]
`include "pot_map.svh"

package pot_pkg;

  typedef enum logic [3:0] {
    OP_NOP         = 4'h0,
    OP_RESTORE     = 4'h1,
    OP_SAVE        = 4'h2,
    OP_NV_WRITE    = 4'h3,
    OP_SHR_ONE     = 4'h4,
    OP_SHR_ALL     = 4'h5,
    OP_DEC_ONE     = 4'h6,
    OP_DEC_ALL     = 4'h7,
    OP_RESTORE_ALL = 4'h8,
    OP_NV_READ     = 4'h9,
    OP_WIPER_READ  = 4'hA,
    OP_WIPER_WRITE = 4'hB,
    OP_SHL_ONE     = 4'hC,
    OP_SHL_ALL     = 4'hD,
    OP_INC_ONE     = 4'hE,
    OP_INC_ALL     = 4'hF
  } cmd_t;

  typedef struct packed {
    cmd_t                    cmd;
    logic [`ADDR_BITS-1:0]   addr;
    logic [`DATA_BITS-1:0]   data;
  } frame_t;

  typedef struct packed {
    frame_t                  word;
    logic [`POS_BITS-1:0]    pos;
    logic                    whole;
    logic                    seen_ack;
  } link_status_t;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_IDLE    = 2'b01,
    ST_EXEC    = 2'b10,
    ST_PRESET  = 2'b11
  } ctrl_state_t;

  typedef logic [`WIPER_BITS-1:0] wiper_t;

endpackage

// [core/serial_frame_rx.sv]
`timescale 1ns/10ps

module serial_frame_rx
  import pot_pkg::*;
(
  input  wire logic   sclk,
  input  wire logic   sys_rst,
  input  wire logic   cs_n,
  input  wire logic   sdi,
  input  wire logic   ack_tgl,
  input  wire frame_t echo_word,
  output link_status_t status,
  output logic        sdo_oe
);

  logic [`FRAME_BITS-1:0] sr_r;
  logic [`POS_BITS-1:0]   pos_r;
  logic                   done_r;
  logic                   seen_ack_r;
  logic                   out_bit_r;
  logic                   new_frame;
  logic [`POS_BITS-1:0]   base_pos;
  logic [`FRAME_BITS-1:0] sr_src;

  // Ack toggle is quasi-static here: it only moves while chip select is high
  assign new_frame = (ack_tgl != seen_ack_r);
  assign base_pos  = (new_frame && (pos_r[1:0] != 2'h0)) ? `POS_FIRST : pos_r;
  assign sr_src    = new_frame ? echo_word : sr_r;

  // Link clock may stop outside frames, so reset is applied without it
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_r       <= '0;
      pos_r      <= `POS_FIRST;
      done_r     <= 1'b0;
      seen_ack_r <= 1'b0;
    end else begin
      sr_r       <= {sr_src[`FRAME_MSB-1:0], sdi};
      pos_r      <= (base_pos == `POS_LAST) ? `POS_FIRST : base_pos + 5'h01;
      done_r     <= (new_frame ? 1'b0 : done_r) | (base_pos == `POS_LAST);
      seen_ack_r <= ack_tgl;
    end
  end

  // Output changes on the falling edge so the master samples a settled bit
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_bit_r <= 1'b1;
    end else begin
      out_bit_r <= sr_r[`FRAME_MSB];
    end
  end

  // Open drain: drive only a low bit, and only inside a frame
  assign sdo_oe = ~cs_n & ~(new_frame ? echo_word[`FRAME_MSB] : out_bit_r);

  assign status.word     = sr_r;
  assign status.pos      = pos_r;
  assign status.whole    = done_r;
  assign status.seen_ack = seen_ack_r;

endmodule

// [core/nv_word_store.sv]
`timescale 1ns/10ps

module nv_word_store
  import pot_pkg::*;
#(
  parameter logic [`DATA_BITS-1:0] TOL_WORD = `NV_FACTORY_TOL
)
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire logic [`ADDR_BITS-1:0] wr_addr,
  input  wire logic [`DATA_BITS-1:0] wr_data,
  input  wire logic [`ADDR_BITS-1:0] rd_addr,
  output logic      [`DATA_BITS-1:0] rd_data,
  output logic      [`DATA_BITS-1:0] saved_one,
  output logic      [`DATA_BITS-1:0] saved_two
);

  logic [`DATA_BITS-1:0] mem_r [`NV_WORDS];

  // Reset stands in for the factory programmed contents
  for (genvar i = 0; i < `NV_WORDS; i++) begin : g_word
    localparam logic [`ADDR_BITS-1:0] ADDR = i[`ADDR_BITS-1:0];
    localparam logic [`DATA_BITS-1:0] INIT =
      (ADDR == `NV_ADDR_TOLERANCE) ? TOL_WORD :
      ((ADDR == `NV_ADDR_SAVED_ONE) || (ADDR == `NV_ADDR_SAVED_TWO)) ?
      `NV_FACTORY_WIPER : `NV_FACTORY_USER;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mem_r[i] <= INIT;
      end else if (wr_en && (wr_addr == ADDR) && (ADDR != `NV_ADDR_TOLERANCE)) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  assign rd_data   = mem_r[rd_addr];
  assign saved_one = mem_r[`NV_ADDR_SAVED_ONE];
  assign saved_two = mem_r[`NV_ADDR_SAVED_TWO];

endmodule

// [core/dual_wiper_serial_command_decoder.sv]
`timescale 1ns/10ps

module dual_wiper_serial_command_decoder
  import pot_pkg::*;
#(
  parameter logic [`DATA_BITS-1:0] TOL_WORD = `NV_FACTORY_TOL
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  input  wire logic wp_n,
  input  wire logic preset_strobe_n,
  output logic      sdo_o,
  output logic      sdo_oe,
  output wiper_t    wiper_one,
  output wiper_t    wiper_two
);

  ctrl_state_t           state_r;
  ctrl_state_t           state_nxt;
  link_status_t          link_status;
  frame_t                cur_r;
  frame_t                last_r;
  frame_t                echo_r;
  logic                  has_last_r;
  logic                  ack_tgl_r;
  logic                  cs_s1_r;
  logic                  cs_s2_r;
  logic                  cs_s3_r;
  logic                  wp_s1_r;
  logic                  wp_s2_r;
  logic                  pr_s1_r;
  logic                  pr_s2_r;
  logic                  pr_s3_r;
  logic                  cs_rise;
  logic                  pr_fall;
  logic                  pr_rise;
  logic                  frame_empty;
  logic                  frame_whole;
  logic                  run_cmd;
  logic                  protect;
  logic                  nv_wr_en;
  logic [`ADDR_BITS-1:0] nv_wr_addr;
  logic [`DATA_BITS-1:0] nv_wr_data;
  logic [`ADDR_BITS-1:0] nv_rd_addr;
  logic [`DATA_BITS-1:0] nv_rd_data;
  logic [`DATA_BITS-1:0] saved_one;
  logic [`DATA_BITS-1:0] saved_two;
  wiper_t                wiper_r   [2];
  wiper_t                wiper_nxt [2];
  wiper_t                saved_w   [2];
  wiper_t                sel_wiper;

  serial_frame_rx u_rx (
    .sclk      (sclk),
    .sys_rst   (sys_rst),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .ack_tgl   (ack_tgl_r),
    .echo_word (echo_r),
    .status    (link_status),
    .sdo_oe    (sdo_oe)
  );

  nv_word_store #(
    .TOL_WORD (TOL_WORD)
  ) u_store (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr_en     (nv_wr_en),
    .wr_addr   (nv_wr_addr),
    .wr_data   (nv_wr_data),
    .rd_addr   (nv_rd_addr),
    .rd_data   (nv_rd_data),
    .saved_one (saved_one),
    .saved_two (saved_two)
  );

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      pr_s1_r <= 1'b1;
      pr_s2_r <= 1'b1;
      pr_s3_r <= 1'b1;
    end else begin
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
      pr_s1_r <= preset_strobe_n;
      pr_s2_r <= pr_s1_r;
      pr_s3_r <= pr_s2_r;
    end
  end

  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign pr_fall = ~pr_s2_r & pr_s3_r;
  assign pr_rise = pr_s2_r & ~pr_s3_r;
  assign protect = ~wp_s2_r;

  // Link state is frozen while select is high, so it is read here safely
  assign frame_empty = (link_status.seen_ack != ack_tgl_r);
  assign frame_whole = ~frame_empty && link_status.whole
                       && (link_status.pos == `POS_FIRST);
  assign run_cmd     = cs_rise && (frame_whole || (frame_empty && has_last_r));

  // Control sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWERUP: state_nxt = ST_IDLE;
      ST_IDLE:    state_nxt = run_cmd ? ST_EXEC : ST_IDLE;
      ST_EXEC:    state_nxt = ST_IDLE;
      ST_PRESET:  state_nxt = pr_rise ? ST_IDLE : ST_PRESET;
      default:    state_nxt = ST_IDLE;
    endcase
    if (pr_fall) begin
      state_nxt = ST_PRESET;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Only frames with clock edges are acknowledged; a toggle per bare strobe
  // would cancel itself on the second strobe in a row and hide the repeat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_tgl_r <= 1'b0;
    end else if (cs_rise && !frame_empty) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // Command capture and the remembered command for repeat strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_r      <= '0;
      last_r     <= '0;
      has_last_r <= 1'b0;
    end else if (run_cmd && state_r == ST_IDLE) begin
      cur_r      <= frame_whole ? link_status.word : last_r;
      last_r     <= frame_whole ? link_status.word : last_r;
      has_last_r <= 1'b1;
    end
  end

  assign saved_w[0] = saved_one[`WIPER_BITS-1:0];
  assign saved_w[1] = saved_two[`WIPER_BITS-1:0];
  assign sel_wiper  = wiper_r[cur_r.addr[0]];

  // Nonvolatile access
  always_comb begin
    nv_wr_en   = 1'b0;
    nv_wr_addr = cur_r.addr;
    nv_wr_data = cur_r.data;
    nv_rd_addr = cur_r.addr;
    if (state_r == ST_EXEC && !protect) begin
      case (cur_r.cmd)
        OP_SAVE: begin
          nv_wr_en   = 1'b1;
          nv_wr_addr = {3'h0, cur_r.addr[0]};
          nv_wr_data = {6'h00, sel_wiper};
        end
        OP_NV_WRITE: begin
          nv_wr_en   = 1'b1;
        end
        default: nv_wr_en = 1'b0;
      endcase
    end
  end

  // Readback and daisy-chain word for the next frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      echo_r <= '0;
    end else if (state_r == ST_EXEC) begin
      case (cur_r.cmd)
        OP_NV_READ:    echo_r <= {cur_r.cmd, cur_r.addr, nv_rd_data};
        OP_WIPER_READ: echo_r <= {cur_r.cmd, cur_r.addr, 6'h00, sel_wiper};
        default:       echo_r <= cur_r;
      endcase
    end
  end

  // Per-channel wiper arithmetic
  for (genvar ch = 0; ch < 2; ch++) begin : g_wiper
    logic hit;
    logic all_cmd;

    assign all_cmd = (cur_r.cmd == OP_SHR_ALL) || (cur_r.cmd == OP_DEC_ALL)
                     || (cur_r.cmd == OP_SHL_ALL) || (cur_r.cmd == OP_INC_ALL)
                     || (cur_r.cmd == OP_RESTORE_ALL);
    assign hit     = all_cmd || (cur_r.addr[0] == 1'(ch));

    always_comb begin
      wiper_nxt[ch] = wiper_r[ch];
      case (state_r)
        ST_POWERUP: wiper_nxt[ch] = saved_w[ch];
        ST_PRESET:  wiper_nxt[ch] = pr_rise ? saved_w[ch] : `WIPER_MID;
        ST_EXEC: begin
          if (hit) begin
            case (cur_r.cmd)
              OP_RESTORE, OP_RESTORE_ALL: begin
                wiper_nxt[ch] = saved_w[ch];
              end
              OP_SHR_ONE, OP_SHR_ALL: begin
                if (!protect) wiper_nxt[ch] = wiper_r[ch] >> 1;
              end
              OP_DEC_ONE, OP_DEC_ALL: begin
                if (!protect && wiper_r[ch] != `WIPER_ZERO) begin
                  wiper_nxt[ch] = wiper_r[ch] - `WIPER_ONE;
                end
              end
              OP_WIPER_WRITE: begin
                if (!protect) wiper_nxt[ch] = cur_r.data[`WIPER_BITS-1:0];
              end
              OP_SHL_ONE, OP_SHL_ALL: begin
                if (!protect) begin
                  if (wiper_r[ch] == `WIPER_ZERO) begin
                    wiper_nxt[ch] = `WIPER_ONE;
                  end else if (wiper_r[ch] >= `WIPER_MID) begin
                    wiper_nxt[ch] = `WIPER_FULL;
                  end else begin
                    wiper_nxt[ch] = {wiper_r[ch][`WIPER_BITS-2:0], 1'b0};
                  end
                end
              end
              OP_INC_ONE, OP_INC_ALL: begin
                if (!protect && wiper_r[ch] != `WIPER_FULL) begin
                  wiper_nxt[ch] = wiper_r[ch] + `WIPER_ONE;
                end
              end
              default: wiper_nxt[ch] = wiper_r[ch];
            endcase
          end
        end
        default: wiper_nxt[ch] = wiper_r[ch];
      endcase
      if (pr_fall) begin
        wiper_nxt[ch] = `WIPER_MID;
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        wiper_r[ch] <= `WIPER_MID;
      end else begin
        wiper_r[ch] <= wiper_nxt[ch];
      end
    end
  end

  assign wiper_one = wiper_r[0];
  assign wiper_two = wiper_r[1];

  // Open-drain data pin only ever pulls low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_o <= 1'b0;
    end else begin
      sdo_o <= 1'b0;
    end
  end

endmodule

// [bench/pot_decoder_sva.sv]
`timescale 1ns/10ps

module pot_decoder_sva
  import pot_pkg::*;
(
  input wire logic   clk,
  input wire logic   sys_rst,
  input wire logic   sclk,
  input wire logic   cs_n,
  input wire logic   sdi,
  input wire logic   wp_n,
  input wire logic   preset_strobe_n,
  input wire logic   sdo_o,
  input wire logic   sdo_oe,
  input wire wiper_t wiper_one,
  input wire wiper_t wiper_two
);
  logic       cs_q;
  logic       pr_q;
  logic [3:0] since_evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk) begin
    cs_q <= sys_rst | cs_n;
    pr_q <= sys_rst | preset_strobe_n;
  end

  // Wipers may only move a few cycles after a frame closes or preset moves
  always_ff @(posedge clk) begin
    if (sys_rst || (cs_n && !cs_q) || preset_strobe_n != pr_q) begin
      since_evt <= 4'h0;
    end else if (since_evt != 4'hF) begin
      since_evt <= since_evt + 4'h1;
    end
  end

  sdo_release_a: assert property (cs_n |-> !sdo_oe)
    else $error("sdo driven while deselected");
  sdo_low_a: assert property (sdo_oe |-> sdo_o == 1'b0)
    else $error("sdo driven high");
  exec_late_a: assert property ($changed(wiper_one) |-> since_evt <= 4'h8)
    else $error("wiper one moved outside a command slot");
  exec_two_a: assert property (wiper_two != $past(wiper_two) |-> since_evt inside {[1:8]})
    else $error("wiper two moved outside a command slot");
  frame_hold_a: assert property ((!cs_n && preset_strobe_n) [*8] |=>
    $stable(wiper_one) && $stable(wiper_two))
    else $error("wiper moved during a frame");
  preset_mid_a: assert property (!preset_strobe_n [*6] |->
    wiper_one == 10'h200 && wiper_two == 10'h200)
    else $error("preset did not give midscale");
  reset_mid_a: assert property ($fell(sys_rst) |->
    (wiper_one == 10'h200 && wiper_two == 10'h200) [*3])
    else $error("wipers not restored after reset");
  idle_quiet_a: assert property ($rose(cs_n) |-> !sdo_oe [*4])
    else $error("sdo active after frame end");

  cover property ($changed(wiper_one) && since_evt <= 4'h8);
  cover property (!preset_strobe_n [*6]);
  cover property (sdo_oe ##1 !sdo_oe);
  cover property (!wp_n && $changed(wiper_one));
endmodule

bind dual_wiper_serial_command_decoder pot_decoder_sva u_pot_decoder_sva (
  .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .wp_n(wp_n),
  .preset_strobe_n(preset_strobe_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .wiper_one(wiper_one), .wiper_two(wiper_two));

// [bench/pot_master.sv]
`timescale 1ns/10ps

module pot_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  int slow = 0;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Clock stands low outside frames; n of zero gives a bare select strobe
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rd);
    rd = '0;
    #7;
    cs_n = 1'b0;
    #(n == 0 ? 150 : 16);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #16;
      sclk = 1'b1;
      rd = {rd[46:0], sdo};
      #(16 + slow);
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    sdi = ~sdi;
    #500;
  endtask
endmodule

// [bench/dual_wiper_serial_command_decoder_test.sv]
`timescale 1ns/10ps

module dual_wiper_serial_command_decoder_test
  import pot_pkg::*;
;
  localparam logic [15:0] TOL = 16'h8C0F;
  logic        clk;
  logic        sys_rst;
  logic        wp_n;
  logic        preset_strobe_n;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo_o;
  logic        sdo_oe;
  wiper_t      wiper_one;
  wiper_t      wiper_two;
  wiper_t      ew [2];
  logic [15:0] nv [16];
  logic [23:0] last;
  logic [23:0] got;
  logic [23:0] exp_rd;
  logic [23:0] mask;
  logic [3:0]  c;
  logic [3:0]  a;
  int          error_cnt = 0;
  int          n_tests = 0;
  wiper_t      cv [7] = '{10'h000, 10'h200, 10'h1FF, 10'h000, 10'h3FF, 10'h001, 10'h000};
  cmd_t        cc [7] = '{OP_SHL_ONE, OP_SHL_ALL, OP_SHL_ONE, OP_DEC_ONE, OP_INC_ALL,
                          OP_SHR_ALL, OP_SHR_ONE};
  // Pull-up on the open-drain output
  wire         sdo = sdo_oe ? sdo_o : 1'b1;

  dual_wiper_serial_command_decoder #(.TOL_WORD(TOL)) u_dual_wiper_serial_command_decoder (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .wp_n(wp_n),
    .preset_strobe_n(preset_strobe_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .wiper_one(wiper_one), .wiper_two(wiper_two));
  pot_master u_pot_master (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic wiper_t step(input cmd_t k, input wiper_t v, input logic [15:0] d);
    case (k)
      OP_SHR_ONE, OP_SHR_ALL: return v >> 1;
      OP_DEC_ONE, OP_DEC_ALL: return (v == 10'h000) ? v : v - 10'h001;
      OP_SHL_ONE, OP_SHL_ALL: return (v == 10'h000) ? 10'h001 :
        (v >= 10'h200) ? 10'h3FF : v << 1;
      OP_INC_ONE, OP_INC_ALL: return (v == 10'h3FF) ? v : v + 10'h001;
      OP_WIPER_WRITE: return d[9:0];
      default: return v;
    endcase
  endfunction

  task automatic cmp_w();
    n_tests++;
    if (wiper_one !== ew[0] || wiper_two !== ew[1]) begin
      error_cnt++;
      $display("ERROR %0t wipers %h %h expected %h %h", $time, wiper_one, wiper_two, ew[0], ew[1]);
    end
  endtask

  task automatic cmp_rd(input logic [23:0] g, input logic [23:0] e, input logic [23:0] m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("ERROR %0t readback %h expected %h", $time, g, e);
    end
  endtask

  // Reference for one executed word, including the word echoed next frame
  task automatic model(input logic [23:0] w);
    cmd_t       k;
    logic [3:0] ad;
    k = cmd_t'(w[23:20]);
    ad = w[19:16];
    mask = wp_n ? 24'hFFFFFF : 24'h000000;
    exp_rd = w;
    if (k == OP_RESTORE) ew[ad[0]] = nv[ad[0]][9:0];
    else if (k == OP_RESTORE_ALL) begin
      ew[0] = nv[0][9:0];
      ew[1] = nv[1][9:0];
    end else if (k == OP_NV_READ) begin
      exp_rd[15:0] = nv[ad];
      if (ad < 4'h2) mask = 24'hFF03FF;
    end else if (k == OP_WIPER_READ) begin
      exp_rd[9:0] = ew[ad[0]];
      mask = 24'h0003FF;
    end else if (wp_n) begin
      if (k == OP_SAVE) nv[ad[0]] = {6'h00, ew[ad[0]]};
      else if (k == OP_NV_WRITE && ad != 4'hF) nv[ad] = w[15:0];
      else if (k[2] && k[0]) begin
        ew[0] = step(k, ew[0], w[15:0]);
        ew[1] = step(k, ew[1], w[15:0]);
      end else ew[ad[0]] = step(k, ew[ad[0]], w[15:0]);
    end
  endtask

  task automatic run(input logic [47:0] w, input int n);
    logic [47:0] r;
    u_pot_master.xfer(w, n, r);
    if (n > 0 && n % 24 == 0) begin
      r = r >> (n - 24);
      got = r[23:0];
      cmp_rd(got, exp_rd, mask);
      last = w[23:0];
    end
    if (n % 24 == 0) model(last);
    else mask = 24'h000000;
  endtask

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (nv[i]) nv[i] = 16'h0000;
    nv[0] = 16'h0200;
    nv[1] = 16'h0200;
    nv[15] = TOL;
    ew = '{10'h200, 10'h200};
    mask = 24'h000000;
    repeat (4) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // About 120 frames of some 1.3 us each, the later slow-clock frames nearer 2.3 us
  initial begin
    #2000000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    void'($urandom(32'h0227));
    sys_rst = 1'b1;
    wp_n = 1'b1;
    preset_strobe_n = 1'b1;
    do_reset();
    cmp_w();
    // Saturation corners; don't-care data bits set high on the wiper one writes
    foreach (cv[i]) begin
      run({24'h0, OP_WIPER_WRITE, 4'h0, 6'h3F, cv[i]}, 24);
      run({24'h0, OP_WIPER_WRITE, 4'h1, 6'h00, cv[i]}, 24);
      run({24'h0, cc[i], 4'h0, 16'h0000}, 24);
      cmp_w();
    end
    for (int k = 0; k < 80; k++) begin
      u_pot_master.slow = (k > 40) ? 40 : 0;
      c = 4'($urandom);
      a = (c == 4'h3) ? 4'($urandom_range(14, 2)) :
          (c == 4'h9 || c == 4'h0 || (c[2] && c[0])) ? 4'($urandom) : {3'b000, 1'($urandom)};
      run({24'h0, c, a, 16'($urandom)}, 24);
      cmp_w();
    end
    run({24'h0, OP_NV_WRITE, 4'hF, 16'h1234}, 24);
    run({24'h0, OP_NV_READ, 4'hF, 16'h0000}, 24);
    run({24'h0, OP_NOP, 4'h5, 16'hFFFF}, 24);
    cmp_rd(got, {OP_NV_READ, 4'hF, TOL}, 24'hFFFFFF);
    run({24'h0, OP_WIPER_WRITE, 4'h1, 16'h00F0}, 24);
    run({24'h0, OP_INC_ONE, 4'h1, 16'h0000}, 24);
    run(48'h0, 0);
    cmp_w();
    run(48'h0, 0);
    cmp_w();
    run({24'h0, OP_WIPER_WRITE, 4'h0, 16'h02AA}, 23);
    cmp_w();
    run({OP_WIPER_WRITE, 4'h0, 16'h0111, OP_WIPER_WRITE, 4'h1, 16'h0222}, 48);
    cmp_w();
    run({24'h0, OP_WIPER_WRITE, 4'h0, 16'h00AB}, 24);
    run({24'h0, OP_SAVE, 4'h0, 16'h0000}, 24);
    run({24'h0, OP_WIPER_WRITE, 4'h0, 16'h0155}, 24);
    @(posedge clk);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (cc[i]) run({24'h0, cc[i], 4'h0, 16'h0000}, 24);
    run({24'h0, OP_WIPER_WRITE, 4'h1, 16'h03C3}, 24);
    run({24'h0, OP_SAVE, 4'h0, 16'h0000}, 24);
    cmp_w();
    run({24'h0, OP_RESTORE, 4'h0, 16'h0000}, 24);
    cmp_w();
    @(posedge clk);
    wp_n <= 1'b1;
    preset_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    ew = '{10'h200, 10'h200};
    cmp_w();
    preset_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    model({OP_RESTORE_ALL, 20'h00000});
    mask = 24'h000000;
    cmp_w();
    do_reset();
    cmp_w();
    finish_test();
  end
endmodule
